// ==== stme_pkg.sv ====
// Purpose: constants and types for the status transfer / multiply unit
// Assumes: 32-bit data, APB register access, one clock
// Notes:   reserved status bits are not stored and read as zero
package stme_pkg;
	// ==========================================================
	// Register map (byte offsets)
	localparam int          ADDR_W     = 8;
	localparam logic [7:0]  OFS_INSTR  = 8'h00;
	localparam logic [7:0]  OFS_OPA    = 8'h04;
	localparam logic [7:0]  OFS_OPB    = 8'h08;
	localparam logic [7:0]  OFS_OPC    = 8'h0C;
	localparam logic [7:0]  OFS_RESULT = 8'h10;
	localparam logic [7:0]  OFS_LIVE   = 8'h14;
	localparam logic [7:0]  OFS_BANK   = 8'h18;
	localparam logic [7:0]  OFS_STAT   = 8'h1C;
	// ==========================================================
	// Status word layout
	localparam logic [31:0] PSR_MASK   = 32'hF00000FF;
	localparam logic [31:0] LIVE_RST   = 32'h000000D3;
	localparam int          FLAG_HI    = 31;
	localparam int          FLAG_LO    = 28;
	localparam int          BIT_Z      = 30;
	localparam logic [4:0]  MODE_USR   = 5'h10;
	localparam logic [4:0]  MODE_FIQ   = 5'h11;
	localparam logic [4:0]  MODE_IRQ   = 5'h12;
	localparam logic [4:0]  MODE_SVC   = 5'h13;
	localparam logic [4:0]  MODE_ABT   = 5'h17;
	localparam logic [4:0]  MODE_UND   = 5'h1B;
	localparam int          BANK_N     = 5;
	// ==========================================================
	// Instruction encoding
	localparam logic [5:0]  MUL_OPC    = 6'h00;
	localparam logic [3:0]  MUL_SIG    = 4'h9;
	localparam logic [1:0]  PSR_OP_HI  = 2'h0;
	localparam logic [1:0]  PSR_OP_MID = 2'h2;
	localparam logic [3:0]  FLD_ALL    = 4'hF;
	localparam logic [3:0]  FLD_WHOLE  = 4'h9;
	localparam logic [3:0]  FLD_FLAGS  = 4'h8;
	localparam int          MUL_CHUNK  = 8;
	localparam logic [2:0]  MUL_M_MAX  = 3'h4;
	// ==========================================================
	// Status register fields
	localparam int ST_BUSY = 0;
	localparam int ST_DONE = 1;
	localparam int ST_SKIP = 2;
	localparam int ST_BAD  = 3;
	localparam int ST_RDW  = 4;
	localparam int ST_DEST = 8;
	localparam int ST_CYC  = 16;
	// ==========================================================
	// Types
	typedef enum logic [3:0] {
		CC_EQ, CC_NE, CC_CS, CC_CC, CC_MI, CC_PL, CC_VS, CC_VC,
		CC_HI, CC_LS, CC_GE, CC_LT, CC_GT, CC_LE, CC_AL, CC_NV
	} stme_cond_e;
	typedef enum logic [1:0] {KIND_BAD, KIND_READ, KIND_WRITE, KIND_MUL} stme_kind_e;
	typedef enum logic [3:0] {
		ST_IDLE  = 4'b0001,
		ST_SEQ   = 4'b0010,
		ST_ARRAY = 4'b0100,
		ST_ACC   = 4'b1000
	} stme_state_e;
	typedef struct packed {
		stme_kind_e kind;        // Instruction group
		stme_cond_e cond;        // Condition field
		logic       set_flags;   // S bit
		logic       accumulate;  // A bit
		logic       use_banked;  // Banked word selected
		logic       flags_only;  // Flags-only target
		logic       immediate;   // Rotated immediate source
		logic [3:0] dest;        // Destination register number
	} stme_dec_s;
endpackage : stme_pkg

// ==== stme_cond.sv ====
// Purpose: condition field evaluation against N, Z, C, V
// Assumes: flags ordered N, Z, C, V from bit 3 down
// Notes:   purely combinational
`timescale 1ns/100ps
module stme_cond
	import stme_pkg::*;
(
	input  wire stme_pkg::stme_cond_e cond,
	input  wire logic [3:0]           nzcv,
	output logic                      pass
);
	// ==========================================================
	// Evaluation
	logic n, z, c, v;
	assign n = nzcv[3];
	assign z = nzcv[2];
	assign c = nzcv[1];
	assign v = nzcv[0];

	// Never-code gives false so the instruction has no effect
	always_comb
	begin
		case (cond)
			CC_EQ:   pass = z;
			CC_NE:   pass = !z;
			CC_CS:   pass = c;
			CC_CC:   pass = !c;
			CC_MI:   pass = n;
			CC_PL:   pass = !n;
			CC_VS:   pass = v;
			CC_VC:   pass = !v;
			CC_HI:   pass = c && !z;
			CC_LS:   pass = !c || z;
			CC_GE:   pass = n == v;
			CC_LT:   pass = n != v;
			CC_GT:   pass = !z && (n == v);
			CC_LE:   pass = z || (n != v);
			CC_AL:   pass = 1'b1;
			default: pass = 1'b0;
		endcase
	end
endmodule : stme_cond

// ==== stme_booth.sv ====
// Purpose: 32x8 iterative multiplier with early termination
// Assumes: start is a one-cycle pulse while idle
// Notes:   last and prod are combinational for the final cycle
`timescale 1ns/100ps
module stme_booth
	import stme_pkg::*;
(
	input  wire logic        pclk,
	input  wire logic        presetn,
	input  wire logic        start,
	input  wire logic [31:0] mcand,
	input  wire logic [31:0] mplier,
	output logic             last,
	output logic [31:0]      prod,
	output logic [2:0]       m_out
);
	// ==========================================================
	// State
	logic [31:0] mc_reg;   // Multiplicand, shifted per chunk
	logic [31:0] mp_reg;   // Multiplier, shifted per chunk
	logic [31:0] acc_reg;  // Partial low product
	logic [2:0]  m_reg;    // Array cycles needed
	logic [2:0]  cnt_reg;  // Array cycles done
	logic        neg_reg;  // Multiplier bit 31; upper bits all ones when it ends early
	logic        busy_reg;
	logic [2:0]  m_calc;
	logic [31:0] part;
	logic [31:0] corr;

	// Uniform upper bits end the iteration early
	always_comb
	begin
		if ((&mplier[31:8]) || !(|mplier[31:8]))
			m_calc = 3'h1;
		else if ((&mplier[31:16]) || !(|mplier[31:16]))
			m_calc = 3'h2;
		else if ((&mplier[31:24]) || !(|mplier[31:24]))
			m_calc = 3'h3;
		else
			m_calc = MUL_M_MAX;
	end

	// One 32x8 array step; upper ones stand for minus 2^(8m)
	assign part  = mc_reg * {24'h000000, mp_reg[MUL_CHUNK-1:0]};
	assign last  = busy_reg && ((cnt_reg + 3'h1) == m_reg);
	assign corr  = (last && neg_reg && (m_reg != MUL_M_MAX)) ? (mc_reg << MUL_CHUNK) : 32'h0;
	assign prod  = acc_reg + part - corr;
	assign m_out = m_reg;

	// ==========================================================
	// Iteration
	always_ff @(posedge pclk or negedge presetn)
	begin
		if (!presetn)
		begin
			mc_reg   <= 32'h0;
			mp_reg   <= 32'h0;
			acc_reg  <= 32'h0;
			m_reg    <= 3'h1;
			cnt_reg  <= 3'h0;
			neg_reg  <= 1'b0;
			busy_reg <= 1'b0;
		end
		else if (start)
		begin
			mc_reg   <= mcand;
			mp_reg   <= mplier;
			acc_reg  <= 32'h0;
			m_reg    <= m_calc;
			cnt_reg  <= 3'h0;
			neg_reg  <= mplier[31];
			busy_reg <= 1'b1;
		end
		else if (busy_reg)
		begin
			acc_reg  <= prod;
			mc_reg   <= mc_reg << MUL_CHUNK;
			mp_reg   <= mp_reg >> MUL_CHUNK;
			cnt_reg  <= cnt_reg + 3'h1;
			busy_reg <= !last;
		end
	end

	// Never more array cycles than chunks in the word
	chunk_bound_a: assert property (@(posedge pclk) disable iff (!presetn)
		busy_reg |-> (cnt_reg < m_reg) && (m_reg <= MUL_M_MAX))
		else $error("multiplier ran past its chunk count");
endmodule : stme_booth

// ==== stme_exec.sv ====
// Purpose: status word transfer and 32-bit multiply execution unit
// Assumes: APB master; operand values loaded before an instruction
// Notes:   writes are refused with pslverr while an instruction runs
`timescale 1ns/100ps
module stme_exec
	import stme_pkg::*;
(
	input  wire logic              pclk,
	input  wire logic              presetn,
	input  wire logic              psel,
	input  wire logic              penable,
	input  wire logic              pwrite,
	input  wire logic [ADDR_W-1:0] paddr,
	input  wire logic [31:0]       pwdata,
	output logic      [31:0]       prdata,
	output logic                   pready,
	output logic                   pslverr,
	output logic                   exec_busy
);
	import stme_pkg::*;

	// ==========================================================
	// Storage
	logic [31:0] instr_reg;   // Instruction under execution
	logic [31:0] opa_reg;     // Source / multiplicand value
	logic [31:0] opb_reg;     // Multiplier value
	logic [31:0] opc_reg;     // Addend value
	logic [31:0] result_reg;  // Value for the destination register
	logic [31:0] live_reg;    // Live status word
	logic [31:0] live_next;
	logic [31:0] bank_reg [BANK_N]; // Banked copies per privileged mode
	logic [31:0] hold_reg;    // Product waiting for the add step
	stme_state_e state_reg;
	logic        done_reg, skip_reg, bad_reg, rdw_reg;
	logic [3:0]  dest_reg;
	logic [3:0]  cyc_reg;     // Cycles spent in current instruction
	logic [3:0]  cycles_reg;  // Cycles of last finished instruction
	logic        pready_reg, pslverr_reg, busy_out_reg;
	logic [31:0] prdata_reg;

	// ==========================================================
	// Decode
	stme_dec_s   dec;
	logic [31:0] imm32, src, bank_cur, fin_val;
	logic [2:0]  bank_idx;
	logic        bank_ok, user_mode, cond_ok, in_seq, go;
	logic        psr_wr, live_flg, live_all, bank_wr, fin_mul, fin_any;
	logic        wr_acc, setup, busy, instr_wr, mul_last;
	logic [31:0] mul_prod;
	logic [2:0]  mul_m;

	always_comb
	begin
		dec            = '0;
		dec.cond       = stme_cond_e'(instr_reg[31:28]);
		dec.set_flags  = instr_reg[20];
		dec.accumulate = instr_reg[21];
		dec.use_banked = instr_reg[22];
		dec.immediate  = instr_reg[25];
		dec.flags_only = instr_reg[19:16] == FLD_FLAGS;
		dec.kind       = KIND_BAD;
		dec.dest       = instr_reg[15:12];
		if (instr_reg[27:22] == MUL_OPC && instr_reg[7:4] == MUL_SIG)
		begin
			dec.kind = KIND_MUL;
			dec.dest = instr_reg[19:16];
		end
		else if (instr_reg[27:26] == PSR_OP_HI && instr_reg[24:23] == PSR_OP_MID
		         && !instr_reg[20])
		begin
			// Whole and plain target names share one encoding
			if (!instr_reg[21] && instr_reg[19:16] == FLD_ALL && !instr_reg[25])
				dec.kind = KIND_READ;
			else if (instr_reg[21] && instr_reg[15:12] == FLD_ALL
			         && (instr_reg[19:16] == FLD_WHOLE || dec.flags_only))
				dec.kind = KIND_WRITE;
		end
	end

	// 8-bit field rotated right by twice the 4-bit amount
	always_comb
	begin
		imm32 = 32'({instr_reg[7:0], 24'h0, instr_reg[7:0], 24'h0}
		            >> ({instr_reg[11:8], 1'b0} + 6'h18));
	end

	// Banked copy index from the current mode; user has none
	always_comb
	begin
		bank_ok  = 1'b1;
		case (live_reg[4:0])
			MODE_FIQ: bank_idx = 3'h0;
			MODE_IRQ: bank_idx = 3'h1;
			MODE_SVC: bank_idx = 3'h2;
			MODE_ABT: bank_idx = 3'h3;
			MODE_UND: bank_idx = 3'h4;
			default:
			begin
				bank_idx = 3'h0;
				bank_ok  = 1'b0;
			end
		endcase
	end

	assign user_mode = live_reg[4:0] == MODE_USR;
	assign bank_cur  = bank_ok ? bank_reg[bank_idx] : live_reg;
	assign src       = dec.immediate ? imm32 : opa_reg;
	assign in_seq    = state_reg == ST_SEQ;
	assign go        = in_seq && cond_ok && dec.kind != KIND_BAD;
	assign psr_wr    = go && dec.kind == KIND_WRITE;
	assign live_flg  = psr_wr && !dec.use_banked && dec.flags_only;
	assign live_all  = psr_wr && !dec.use_banked && !dec.flags_only;
	assign bank_wr   = psr_wr && dec.use_banked && bank_ok;
	assign fin_mul   = (state_reg == ST_ARRAY && mul_last && !dec.accumulate)
	                 || state_reg == ST_ACC;
	assign fin_any   = (in_seq && !(go && dec.kind == KIND_MUL)) || fin_mul;
	// Plain form never looks at the addend value
	assign fin_val   = (state_reg == ST_ACC) ? hold_reg + opc_reg : mul_prod;

	stme_cond u_cond (
		.cond (dec.cond),
		.nzcv (live_reg[FLAG_HI:FLAG_LO]),
		.pass (cond_ok)
	);

	// Multiplicand and multiplier are latched at start, so the destination may share a register
	// with either of them without corrupting the result; the addend is read from opc_reg at the add step
	stme_booth u_booth (
		.pclk    (pclk),
		.presetn (presetn),
		.start   (go && dec.kind == KIND_MUL),
		.mcand   (opa_reg),
		.mplier  (opb_reg),
		.last    (mul_last),
		.prod    (mul_prod),
		.m_out   (mul_m)
	);

	// ==========================================================
	// APB slave
	assign busy     = state_reg != ST_IDLE;
	assign setup    = psel && !penable;
	assign wr_acc   = psel && penable && pwrite && pready_reg && !pslverr_reg;
	assign instr_wr = wr_acc && paddr == OFS_INSTR;

	// Zero wait states: answer prepared during the setup cycle
	always_ff @(posedge pclk or negedge presetn)
	begin
		if (!presetn)
		begin
			pready_reg  <= 1'b0;
			pslverr_reg <= 1'b0;
			prdata_reg  <= 32'h0;
		end
		else
		begin
			pready_reg  <= setup;
			pslverr_reg <= 1'b0;
			prdata_reg  <= 32'h0;
			if (setup)
			begin
				case (paddr)
					OFS_INSTR:  prdata_reg <= instr_reg;
					OFS_OPA:    prdata_reg <= opa_reg;
					OFS_OPB:    prdata_reg <= opb_reg;
					OFS_OPC:    prdata_reg <= opc_reg;
					OFS_RESULT: prdata_reg <= result_reg;
					OFS_LIVE:   prdata_reg <= live_reg;
					OFS_BANK:   prdata_reg <= bank_cur;
					OFS_STAT:
					begin
						prdata_reg[ST_BUSY]          <= busy;
						prdata_reg[ST_DONE]          <= done_reg;
						prdata_reg[ST_SKIP]          <= skip_reg;
						prdata_reg[ST_BAD]           <= bad_reg;
						prdata_reg[ST_RDW]           <= rdw_reg;
						prdata_reg[ST_DEST +: 4]     <= dest_reg;
						prdata_reg[ST_CYC +: 4]      <= cycles_reg;
					end
					default:    pslverr_reg <= 1'b1;
				endcase
				// Results would be torn if inputs moved mid-instruction
				if (pwrite && (busy || paddr == OFS_RESULT || paddr == OFS_STAT))
					pslverr_reg <= 1'b1;
			end
		end
	end

	// Operand and instruction registers
	always_ff @(posedge pclk or negedge presetn)
	begin
		if (!presetn)
		begin
			instr_reg <= 32'h0;
			opa_reg   <= 32'h0;
			opb_reg   <= 32'h0;
			opc_reg   <= 32'h0;
		end
		else if (wr_acc)
		begin
			case (paddr)
				OFS_INSTR: instr_reg <= pwdata;
				OFS_OPA:   opa_reg   <= pwdata;
				OFS_OPB:   opb_reg   <= pwdata;
				OFS_OPC:   opc_reg   <= pwdata;
				default:   ;
			endcase
		end
	end

	// ==========================================================
	// Sequencer
	always_ff @(posedge pclk or negedge presetn)
	begin
		if (!presetn)
			state_reg <= ST_IDLE;
		else
		begin
			case (state_reg)
				ST_IDLE:  if (instr_wr) state_reg <= ST_SEQ;
				// Status transfers end after this single cycle
				ST_SEQ:   state_reg <= (go && dec.kind == KIND_MUL) ? ST_ARRAY : ST_IDLE;
				ST_ARRAY: if (mul_last) state_reg <= dec.accumulate ? ST_ACC : ST_IDLE;
				ST_ACC:   state_reg <= ST_IDLE;
				default:  state_reg <= ST_IDLE;
			endcase
		end
	end

	// Result, outcome flags and cycle count
	always_ff @(posedge pclk or negedge presetn)
	begin
		if (!presetn)
		begin
			result_reg <= 32'h0;
			hold_reg   <= 32'h0;
			{done_reg, skip_reg, bad_reg, rdw_reg} <= 4'h0;
			dest_reg   <= 4'h0;
			cyc_reg    <= 4'h0;
			cycles_reg <= 4'h0;
		end
		else
		begin
			cyc_reg <= instr_wr ? 4'h0 : (busy ? cyc_reg + 4'h1 : cyc_reg);
			if (instr_wr)
				{done_reg, skip_reg, bad_reg, rdw_reg} <= 4'h0;
			if (in_seq)
			begin
				dest_reg <= dec.dest;
				bad_reg  <= dec.kind == KIND_BAD;
				skip_reg <= dec.kind != KIND_BAD && !cond_ok;
			end
			if (go && dec.kind == KIND_READ)
			begin
				// Whole word, reserved bits zero, in any mode
				result_reg <= dec.use_banked ? bank_cur : live_reg;
				rdw_reg    <= 1'b1;
			end
			if (state_reg == ST_ARRAY && mul_last)
				hold_reg <= mul_prod;
			if (fin_mul)
			begin
				result_reg <= fin_val;
				rdw_reg    <= 1'b1;
			end
			if (fin_any)
			begin
				done_reg   <= 1'b1;
				cycles_reg <= cyc_reg + 4'h1;
			end
		end
	end

	// ==========================================================
	// Status words
	always_comb
	begin
		live_next = live_reg;
		if (wr_acc && paddr == OFS_LIVE)
			live_next = pwdata & PSR_MASK;
		else if (live_flg)
			live_next = {src[FLAG_HI:FLAG_LO], live_reg[27:0]};
		else if (live_all)
			live_next = user_mode ? {src[FLAG_HI:FLAG_LO], live_reg[27:0]}
			                      : (src & PSR_MASK);
		else if (fin_mul && dec.set_flags)
			// Carry and overflow are left as they were
			live_next = {fin_val[31], fin_val == 32'h0, live_reg[29:0]};
	end

	always_ff @(posedge pclk or negedge presetn)
	begin
		if (!presetn)
			live_reg <= LIVE_RST;
		else
			live_reg <= live_next;
	end

	// One copy per privileged mode, only the current one moves
	genvar gi;
	generate
		for (gi = 0; gi < BANK_N; gi++)
		begin : g_bank
			always_ff @(posedge pclk or negedge presetn)
			begin
				if (!presetn)
					bank_reg[gi] <= 32'h0;
				else if (bank_ok && bank_idx == 3'(gi))
				begin
					if (wr_acc && paddr == OFS_BANK)
						bank_reg[gi] <= pwdata & PSR_MASK;
					else if (bank_wr && dec.flags_only)
						bank_reg[gi] <= {src[FLAG_HI:FLAG_LO], bank_reg[gi][27:0]};
					else if (bank_wr)
						bank_reg[gi] <= src & PSR_MASK;
				end
			end
		end
	endgenerate

	// ==========================================================
	// Outputs
	always_ff @(posedge pclk or negedge presetn)
	begin
		if (!presetn)
			busy_out_reg <= 1'b0;
		else
			busy_out_reg <= state_reg != ST_IDLE;
	end

	assign prdata    = prdata_reg;
	assign pready    = pready_reg;
	assign pslverr   = pslverr_reg;
	assign exec_busy = busy_out_reg;

	// ==========================================================
	// Checks
	default clocking cb @(posedge pclk); endclocking
	default disable iff (!presetn);

	rsvd_zero_a: assert property ((live_reg & ~PSR_MASK) == 32'h0)
		else $error("reserved live status bits not zero");
	psr_one_a: assert property (in_seq && dec.kind != KIND_MUL |=> state_reg == ST_IDLE && done_reg)
		else $error("status transfer took more than one cycle");
	flag_write_a: assert property (live_flg |=>
		live_reg == {$past(src[FLAG_HI:FLAG_LO]), $past(live_reg[27:0])})
		else $error("flags-only write disturbed control bits");
	user_all_a: assert property (live_all && user_mode |=> live_reg[27:0] == $past(live_reg[27:0]))
		else $error("user whole write changed control bits");
	priv_all_a: assert property (live_all && !user_mode |=> live_reg == ($past(src) & PSR_MASK))
		else $error("privileged whole write not loaded");
	bank_flg_a: assert property (bank_wr && dec.flags_only |=>
		bank_reg[$past(bank_idx)][27:0] == $past(bank_cur[27:0]))
		else $error("banked flag write changed control bits");
	read_copy_a: assert property (go && dec.kind == KIND_READ |=>
		result_reg == $past(dec.use_banked ? bank_cur : live_reg))
		else $error("status read returned wrong word");
	cond_skip_a: assert property (in_seq && !cond_ok |=>
		$stable(result_reg) && $stable(live_reg) && state_reg == ST_IDLE)
		else $error("failed condition still had an effect");
	mul_value_a: assert property (fin_mul |=>
		result_reg == 32'(opa_reg * opb_reg + (dec.accumulate ? opc_reg : 32'h0)))
		else $error("multiply result wrong");
	mul_flags_a: assert property (fin_mul && dec.set_flags |=>
		live_reg[31] == result_reg[31] && live_reg[BIT_Z] == (result_reg == 32'h0)
		&& live_reg[29:28] == $past(live_reg[29:28]))
		else $error("multiply flag update wrong");
	mul_time_a: assert property (fin_mul |=>
		cycles_reg == 4'h1 + {1'b0, mul_m} + {3'h0, dec.accumulate})
		else $error("multiply cycle count wrong");
endmodule : stme_exec

// ==== test_stme_exec.sv ====
// Purpose: self-checking bench for the status transfer / multiply unit
// Assumes: APB master polls STAT until done after every instruction
// Notes:   table rows first, then refusals, busy write and a second reset
`timescale 1ns/100ps
module test_stme_exec;
	import stme_pkg::*;
	// ==========================================================
	// Declarations
	typedef struct packed {
		logic [31:0] ins; // Instruction word
		logic [31:0] opa; // Source or multiplicand
		logic [31:0] opb; // Multiplier
		logic [7:0]  adr; // Register read back
		logic [31:0] want; // Expected value
		logic [3:0]  cyc; // Expected cycles, 0 = skip
	} stme_row_s;
	logic              pclk;
	logic              presetn;
	logic              psel;
	logic              penable;
	logic              pwrite;
	logic [ADDR_W-1:0] paddr;
	logic [31:0]       pwdata;
	logic [31:0]       prdata;
	logic              pready;
	logic              pslverr;
	logic              exec_busy;
	logic [31:0]       rd;           // Last read data
	logic [31:0]       st;           // Last status word
	logic              er;           // Last error response
	int                error_cnt;
	int                total_checks;
	stme_row_s         r [15];       // Ordinary cases
	// ==========================================================
	// Clock and unit
	initial
	begin
		pclk = 1'b0;
		forever #12.5 pclk = ~pclk;
	end
	stme_exec dut (
		.pclk      (pclk),
		.presetn   (presetn),
		.psel      (psel),
		.penable   (penable),
		.pwrite    (pwrite),
		.paddr     (paddr),
		.pwdata    (pwdata),
		.prdata    (prdata),
		.pready    (pready),
		.pslverr   (pslverr),
		.exec_busy (exec_busy)
	);
	// ==========================================================
	// Tasks
	task automatic complete_run;
		if (error_cnt == 0 && total_checks > 0)
			$display("STATUS OK");
		else
			$display("STATUS NOT OK");
		$finish;
	endtask : complete_run
	task automatic cmp(input logic [31:0] got, input logic [31:0] want);
		total_checks++;
		if (got !== want)
		begin
			error_cnt++;
			$display("mismatch at %0t: got %h expected %h", $time, got, want);
		end
	endtask : cmp
	// One transfer; an idle edge first so no signal is set twice in a step
	task automatic apb(input logic w, input logic [7:0] a, input logic [31:0] d);
		@(posedge pclk);
		psel    <= 1'b1;
		penable <= 1'b0;
		pwrite  <= w;
		paddr   <= a;
		pwdata  <= d;
		@(posedge pclk);
		penable <= 1'b1;
		do
			@(posedge pclk);
		while (pready !== 1'b1);
		rd = prdata;
		er = pslverr;
		psel    <= 1'b0;
		penable <= 1'b0;
	endtask : apb
	// Poll status with a bounded count; a hang counts as a mismatch
	task automatic wait_done;
		int n;
		n = 0;
		do
		begin
			apb(1'b0, OFS_STAT, 32'h0);
			n++;
		end
		while ((rd[ST_BUSY] !== 1'b0 || rd[ST_DONE] !== 1'b1) && n < 20);
		// A poll that runs out still shows busy or lacks done, so it mismatches here
		cmp({30'h0, rd[ST_DONE], rd[ST_BUSY]}, 32'h00000002);
		st = rd;
	endtask : wait_done
	// ==========================================================
	// Watchdog: a few thousand cycles is far beyond the whole sequence
	initial
	begin
		repeat (5000) @(posedge pclk);
		error_cnt++;
		complete_run();
	end
	// ==========================================================
	// Main sequence
	initial
	begin
		presetn      = 1'b0;
		psel         = 1'b0;
		penable      = 1'b0;
		pwrite       = 1'b0;
		paddr        = 8'h00;
		pwdata       = 32'h0;
		error_cnt    = 0;
		total_checks = 0;
		r[0]  = '{32'hE10F1000, 32'h0, 32'h0, OFS_RESULT, 32'h000000D3, 4'h1};
		r[1]  = '{32'hE128F002, 32'hAFFFFFFF, 32'h0, OFS_LIVE, 32'hA00000D3, 4'h1};
		r[2]  = '{32'hE328F205, 32'h0, 32'h0, OFS_LIVE, 32'h500000D3, 4'h1};
		r[3]  = '{32'hE169F002, 32'h123456FF, 32'h0, OFS_BANK, 32'h100000FF, 4'h1};
		r[4]  = '{32'hE368F20C, 32'h0, 32'h0, OFS_BANK, 32'hC00000FF, 4'h1};
		r[5]  = '{32'hE14F2000, 32'h0, 32'h0, OFS_RESULT, 32'hC00000FF, 4'h1};
		r[6]  = '{32'hE0010392, 32'hFFFFFFF6, 32'h14, OFS_RESULT, 32'hFFFFFF38, 4'h2};
		r[7]  = '{32'hE0233392, 32'h10000, 32'h12345, OFS_RESULT, 32'h23450005, 4'h5};
		r[8]  = '{32'hE0014392, 32'h3, 32'h12000001, OFS_RESULT, 32'h36000003, 4'h5};
		r[9]  = '{32'hE0010392, 32'h2, 32'hFFFF8000, OFS_RESULT, 32'hFFFF0000, 4'h3};
		r[10] = '{32'hE0110392, 32'h80000000, 32'h1, OFS_LIVE, 32'h900000D3, 4'h2};
		r[11] = '{32'h00010392, 32'h7, 32'h7, OFS_RESULT, 32'h80000000, 4'h0};
		r[12] = '{32'hE129F002, 32'h10, 32'h0, OFS_LIVE, 32'h00000010, 4'h1};
		// Whole-word target code is 9; the plain name assembles to the same code
		r[13] = '{32'hE129F002, 32'hF00000D3, 32'h0, OFS_LIVE, 32'hF0000010, 4'h1};
		r[14] = '{32'hE14F2000, 32'h0, 32'h0, OFS_RESULT, 32'hF0000010, 4'h1};
		repeat (8) @(posedge pclk);
		presetn <= 1'b1;
		// Table: load operands, issue, poll, then read back the target
		foreach (r[i])
		begin
			apb(1'b1, OFS_OPA, r[i].opa);
			apb(1'b1, OFS_OPB, r[i].opb);
			apb(1'b1, OFS_OPC, 32'h00000005);
			apb(1'b1, OFS_INSTR, r[i].ins);
			wait_done();
			apb(1'b0, r[i].adr, 32'h0);
			cmp(rd, r[i].want);
			if (r[i].cyc != 4'h0)
				cmp({28'h0, st[ST_CYC +: 4]}, {28'h0, r[i].cyc});
			else
				cmp({31'h0, st[ST_SKIP]}, 32'h00000001);
		end
		// Refused: write to read-only status, read of an unmapped offset
		apb(1'b1, OFS_STAT, 32'hFFFFFFFF);
		cmp({31'h0, er}, 32'h00000001);
		apb(1'b0, 8'h40, 32'h0);
		cmp({31'h0, er}, 32'h00000001);
		cmp(rd, 32'h00000000);
		// Operand write during a long multiply must not disturb it
		apb(1'b1, OFS_OPA, 32'h00000003);
		apb(1'b1, OFS_OPB, 32'h12000001);
		apb(1'b1, OFS_INSTR, 32'hE0010392);
		apb(1'b1, OFS_OPA, 32'h00000009);
		cmp({31'h0, er}, 32'h00000001);
		cmp({31'h0, exec_busy}, 32'h00000001);
		wait_done();
		apb(1'b0, OFS_RESULT, 32'h0);
		cmp(rd, 32'h36000003);
		// Second reset in mid-run restores the live word, clears the bank
		presetn <= 1'b0;
		repeat (2) @(posedge pclk);
		presetn <= 1'b1;
		apb(1'b0, OFS_LIVE, 32'h0);
		cmp(rd, 32'h000000D3);
		apb(1'b0, OFS_BANK, 32'h0);
		cmp(rd, 32'h00000000);
		complete_run();
	end
endmodule : test_stme_exec
